// >>> dv/enc_link_master.sv
// Purpose: controller clocking position words out of the serial link
// Assumes: 320 ns bit period, clock parked high between frames
// Notes: samples late in the high phase, the data lags each rise
`timescale 1ns/10ps
`default_nettype none
module enc_link_master (
    output logic      link_clk_o,
    input  wire logic link_data_i
);
    initial link_clk_o = 1'b1; // idle high
    task automatic frame(input int n, output logic [31:0] w);
        w = 32'h0;
        // one rise beyond the word ends the frame; rate is the bench's, above long-word limit
        for (int i = 0; i < n + 1; i++) begin
            link_clk_o = 1'b0; // first fall requests the latch
            #140;
            link_clk_o = 1'b1;
            #178;
            if (i < n)
                w = {w[30:0], link_data_i}; // msb first
            #2;
        end
    endtask
endmodule
`default_nettype wire

// >>> dv/enc_serial_port_chk.sv
// Purpose: port-level checks of the encoder serial port
// Assumes: one clock domain, synchronous active-low reset
// Notes: delay bounds leave room for the pin synchronisers
`timescale 1ns/10ps
`default_nettype none
module enc_serial_port_chk #(
    parameter int unsigned SET_FILT_CYC = 20
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // bus
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    // link, pins and fault flags
    input wire logic link_clk_i,
    input wire logic link_data_o,
    input wire logic preset_line_i,
    input wire logic dir_i,
    input wire logic led_o,
    input wire logic status_n_o,
    input wire logic sensor_err_i,
    input wire logic emitter_err_i,
    input wire logic temp_err_i
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [15:0] set_cnt_q;
    logic        req;
    logic        flt;
    assign req = avs_read_i | avs_write_i;
    assign flt = sensor_err_i | emitter_err_i | temp_err_i;
    // saturating count of cycles with the preset line high
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || !preset_line_i) begin
            set_cnt_q <= 16'h0000;
        end else if (set_cnt_q != 16'hffff) begin
            set_cnt_q <= set_cnt_q + 16'h0001;
        end
    end
    sequence s_filt_done;
        set_cnt_q == 16'(SET_FILT_CYC + 8);
    endsequence
    sequence s_req_start;
        req && !$past(req);
    endsequence
    property p_status_inv;
        status_n_o == !led_o;
    endproperty
    a_status_inv: assert property (p_status_inv) else $error("status not led inverse");
    property p_fault_led;
        flt |-> ##[1:8] led_o;
    endproperty
    a_fault_led: assert property (p_fault_led) else $error("fault did not light led");
    property p_fault_latch;
        flt |-> ##8 led_o [*8];
    endproperty
    a_fault_latch: assert property (p_fault_latch) else $error("fault not held");
    property p_wait_first;
        s_req_start |-> avs_waitrequest_o;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait state");
    property p_wait_one;
        req && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait too long");
    property p_bit_stable;
        link_clk_i [*5] |-> $stable(link_data_o);
    endproperty
    a_bit_stable: assert property (p_bit_stable) else $error("data moved late, clock high");
    property p_set_led;
        s_filt_done |-> led_o;
    endproperty
    a_set_led: assert property (p_set_led) else $error("set not acted on");
    property p_set_hold;
        $rose(led_o) |-> led_o [*8];
    endproperty
    a_set_hold: assert property (p_set_hold) else $error("led pulse too short");
    property p_dir_fault;
        $changed(dir_i) |-> ##[1:8] led_o;
    endproperty
    a_dir_fault: assert property (p_dir_fault) else $error("dir change not flagged");
endmodule
`default_nettype wire

// >>> dv/enc_serial_port_tb.sv
// Purpose: self-checking bench of the encoder serial port
// Assumes: shortened set filter and processing counts
// Notes: a small integer model predicts every word
`timescale 1ns/10ps
`default_nettype none
module enc_serial_port_tb;
    localparam int unsigned SET_FILT_CYC = 20;
    logic        ref_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        link_clk_i;
    logic        link_data_o;
    logic        preset_line_i = 1'b0;
    logic        dir_i = 1'b0;
    logic        led_o;
    logic        status_n_o;
    logic        inc_a_o;
    logic        inc_b_o;
    logic [16:0] raw_pos_i = 17'h0;
    logic [2:0]  err = 3'h0;
    logic [31:0] rd;
    logic [31:0] w;
    int          failures = 0;
    int          checked = 0;
    int          seed = 72;
    int          raw_m;
    int          off_m;
    int          k;
    always #20 ref_clk_i = ~ref_clk_i;
    enc_link_master PM (.link_clk_o(link_clk_i), .link_data_i(link_data_o));
    enc_serial_port #(.SET_FILT_CYC(SET_FILT_CYC), .SET_PROC_CYC(50)) DUT (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .link_clk_i(link_clk_i), .link_data_o(link_data_o),
        .preset_line_i(preset_line_i), .set_key_i(1'b0), .dir_i(dir_i),
        .led_o(led_o), .status_n_o(status_n_o), .inc_a_o(inc_a_o), .inc_b_o(inc_b_o),
        .raw_pos_i(raw_pos_i), .sensor_err_i(err[0]), .emitter_err_i(err[1]),
        .temp_err_i(err[2]), .temp_warn_i(1'b0), .temp_i(8'h00));
    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // held until the edge that sees waitrequest low, data taken there
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (avs_waitrequest_o !== 1'b0) begin
            failures++;
            end_of_test();
        end
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    // model: binary or gray position relative to the last set point
    function automatic logic [31:0] pos_m(input logic gray);
        int p;
        p = (raw_m - off_m) & 32'h1ffff;
        return gray ? 32'(p ^ (p >> 1)) : 32'(p);
    endfunction
    task automatic new_raw();
        raw_m = $random(seed) & 32'h1ffff;
        raw_pos_i <= 17'(raw_m);
    endtask
    initial begin
        #3000000;
        failures++;
        end_of_test();
    end
    initial begin
        off_m = 0;
        cyc(16);
        nrst_i <= 1'b1;
        new_raw();
        cmp_flag(status_n_o, 1'b1);
        bus(1'b0, 4'h0, 32'h0);
        cmp_word(rd, 32'hd4);
        bus(1'b0, 4'h1, 32'h0);
        cmp_word(rd, 32'h0);
        bus(1'b1, 4'h9, 32'hffffffff);
        bus(1'b0, 4'h9, 32'h0);
        cmp_word(rd, 32'h0);
        cyc(200);
        bus(1'b0, 4'h3, 32'h0);
        cmp_word(rd, pos_m(1'b0));
        PM.frame(17, w);
        cmp_word(w, pos_m(1'b0));
        // restart inside the monoflop keeps the old word
        rd = pos_m(1'b0);
        new_raw();
        cyc(150);
        PM.frame(17, w);
        cmp_word(w, rd);
        cyc(500);
        PM.frame(17, w);
        cmp_word(w, pos_m(1'b0));
        bus(1'b1, 4'h0, 32'hd6);
        cyc(500);
        PM.frame(17, w);
        cmp_word(w, pos_m(1'b1));
        bus(1'b1, 4'h0, 32'hd4);
        preset_line_i <= 1'b1;
        cyc(10);
        cmp_flag(led_o, 1'b0);
        cyc(20);
        cmp_flag(led_o, 1'b1);
        preset_line_i <= 1'b0;
        off_m = raw_m;
        for (k = 0; k < 200 && led_o === 1'b1; k++) begin
            cyc(1);
        end
        cmp_flag(led_o, 1'b0);
        raw_m = (raw_m + 5) & 32'h1ffff;
        raw_pos_i <= 17'(raw_m);
        cyc(500);
        PM.frame(17, w);
        cmp_word(w, pos_m(1'b0));
        rd = pos_m(1'b0);
        cmp_flag(inc_a_o, rd[5]);
        cmp_flag(inc_b_o, rd[5] ^ rd[4]);
        dir_i <= 1'b1;
        cyc(10);
        cmp_flag(led_o, 1'b1);
        bus(1'b0, 4'h2, 32'h0);
        cmp_flag(rd[3], 1'b1);
        // sensor, emitter and temperature faults, a clearing write must not help in ssi mode
        for (int f = 0; f < 3; f++) begin
            nrst_i <= 1'b0;
            cyc(16);
            nrst_i <= 1'b1;
            cyc(4);
            cmp_flag(led_o, 1'b0);
            err <= 3'(1 << f);
            cyc(2);
            err <= 3'h0;
            cyc(40);
            cmp_flag(status_n_o, 1'b0);
            bus(1'b1, 4'h2, 32'h1f);
            bus(1'b0, 4'h2, 32'h0);
            cmp_flag(rd[f], 1'b1);
        end
        end_of_test();
    end
endmodule
bind enc_serial_port enc_serial_port_chk #(.SET_FILT_CYC(SET_FILT_CYC)) u_chk (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .link_clk_i(link_clk_i), .link_data_o(link_data_o), .preset_line_i(preset_line_i),
    .dir_i(dir_i), .led_o(led_o), .status_n_o(status_n_o), .sensor_err_i(sensor_err_i),
    .emitter_err_i(emitter_err_i), .temp_err_i(temp_err_i));
`default_nettype wire

// >>> hdl/enc_port_pkg.sv
// Purpose: types shared by the encoder serial port
// Assumes: nothing beyond the register header
// Notes: link states only
package enc_port_pkg;
    typedef enum logic [1:0] {
        LNK_IDLE  = 2'b00,
        LNK_SHIFT = 2'b01,
        LNK_MONO  = 2'b10
    } link_state_e;
endpackage

// >>> hdl/enc_port_regs.svh
// Purpose: offsets, field positions, reset values and timing for the encoder serial port
// Assumes: 25 MHz reference clock; register offsets are word indices on the bus
// Notes: the list below summarises the port's behaviour
// Notes on behaviour
// - restart inside 15 us monoflop resends same word in ssi mode; biss always latches fresh
// - restart after monoflop latches and sends fresh position
// - ssi word 10-14 or 17 bits, binary/gray
// - latch jitter under 1 us (4 us long)
// - internal position refreshed faster than 100 kHz
// - zero-set input or key loads zero/preset
// - zero-set input filtered about 1 ms
// - set processing 15 ms, led on, data frozen
// - fault-free: led off, status output high
// - sensor, emitter, temperature faults light led, status low
// - ssi mode faults latch until power off
// - direction input high selects ccw, polarity configurable
// - direction change while powered is a fault
// - biss clock up to 10 MHz, ssi 2 MHz
// - biss position binary, resolution programmable
// - biss position update under 10 us
// - biss frame carries crc over data
// - controller writes parameters over biss link
// - biss sends temperature as multicycle data
// - quadrature a/b outputs, 2048 periods per turn
`ifndef ENC_PORT_REGS_SVH
`define ENC_PORT_REGS_SVH

`define CLK_NS          40
`define MONO_NS         15000
`define MONO_CYC        ((`MONO_NS + `CLK_NS - 1) / `CLK_NS)
`define REFRESH_NS      5000
`define REFRESH_CYC     (`REFRESH_NS / `CLK_NS)
`define SET_FILT_NS     1000000
`define SET_FILT_CYC    ((`SET_FILT_NS + `CLK_NS - 1) / `CLK_NS)
`define SET_PROC_NS     15000000
`define SET_PROC_CYC    ((`SET_PROC_NS + `CLK_NS - 1) / `CLK_NS)

`define REG_CTRL        4'h0
`define REG_PRESET      4'h1
`define REG_STATUS      4'h2
`define REG_POS         4'h3

`define CTRL_BISS       0
`define CTRL_GRAY       1
`define CTRL_RES_LO     2
`define CTRL_DIR_INV    5
`define CTRL_ALARM_EN   6
`define CTRL_WARN_EN    7
`define CTRL_RST        8'hd4
`define PRESET_RST      17'h00000

`define RES_CODE_17     3'h5
`define RES_MAX         5'h11
`define RES_MIN         5'h0a
`define POS_W           17
`define FAULT_W         4
`define CRC_POLY        6'h03
`define INC_A_BIT       5
`define INC_B_BIT       4

`define CDM_W           13
`define PAR_RES         4'h0
`define PAR_GRAY        4'h1
`define PAR_DIR         4'h2
`define PAR_ALARM       4'h3
`define PAR_WARN        4'h4

`endif

// >>> hdl/enc_serial_port.sv
// Purpose: position output of a singleturn absolute encoder over ssi or biss-c
// Assumes: raw angle and fault flags come from logic on ref_clk_i
// Notes: link clock and pins are sampled, so link rates are bounded by ref_clk_i
`timescale 1ns/10ps
`default_nettype none
`include "enc_port_regs.svh"
module enc_serial_port
    import enc_port_pkg::*;
#(
    parameter int unsigned SET_FILT_CYC = `SET_FILT_CYC,
    parameter int unsigned SET_PROC_CYC = `SET_PROC_CYC
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // serial link
    input  wire logic        link_clk_i,
    output logic             link_data_o,
    // pins
    input  wire logic        preset_line_i,
    input  wire logic        set_key_i,
    input  wire logic        dir_i,
    output logic             led_o,
    output logic             status_n_o,
    output logic             inc_a_o,
    output logic             inc_b_o,
    // sensor side
    input  wire logic [16:0] raw_pos_i,
    input  wire logic        sensor_err_i,
    input  wire logic        emitter_err_i,
    input  wire logic        temp_err_i,
    input  wire logic        temp_warn_i,
    input  wire logic [7:0]  temp_i
);
    localparam int unsigned MONO_CYC = `MONO_CYC;
    localparam int unsigned REF_CYC  = `REFRESH_CYC;

    function automatic logic [4:0] res_bits(input logic [2:0] code);
        res_bits = (code >= `RES_CODE_17) ? `RES_MAX : (`RES_MIN + {2'b00, code});
    endfunction

    // crc over the low n bits, msb first
    function automatic logic [5:0] crc6(input logic [18:0] d, input logic [4:0] n);
        logic [5:0] c;
        logic       fb;
        c = 6'h00;
        for (int i = 18; i >= 0; i--) begin
            if (i < int'(n)) begin
                fb = c[5] ^ d[i];
                c  = {c[4:0], 1'b0} ^ (fb ? `CRC_POLY : 6'h00);
            end
        end
        crc6 = c;
    endfunction

    // two-flop synchronisers on every pin
    logic [1:0] ma_s_q, set_s_q, key_s_q, dir_s_q;
    logic       ma_prev_q;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            ma_s_q    <= 2'b11;
            set_s_q   <= 2'b00;
            key_s_q   <= 2'b00;
            dir_s_q   <= 2'b00;
            ma_prev_q <= 1'b1;
        end else begin
            ma_s_q    <= {ma_s_q[0], link_clk_i};
            set_s_q   <= {set_s_q[0], preset_line_i};
            key_s_q   <= {key_s_q[0], set_key_i};
            dir_s_q   <= {dir_s_q[0], dir_i};
            ma_prev_q <= ma_s_q[1];
        end
    end
    logic ma_fall, ma_rise;
    assign ma_fall = ma_prev_q & ~ma_s_q[1];
    assign ma_rise = ~ma_prev_q & ma_s_q[1];

    // configuration and status storage
    logic [7:0]  ctrl_q;
    logic [16:0] preset_q;
    logic [3:0]  fault_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic        set_busy;
    logic [16:0] pos_q;
    logic        par_we;
    logic [3:0]  par_addr;
    logic [7:0]  par_data;
    logic        biss;
    logic [4:0]  res;
    assign biss = ctrl_q[`CTRL_BISS];
    assign res  = res_bits(ctrl_q[`CTRL_RES_LO +: 3]);

    logic        bus_req, bus_we;
    logic [31:0] bmask;
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_we  = avs_write_i & ack_q;
    assign bmask   = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    // answer one cycle after the request is seen
    assign avs_waitrequest_o = bus_req & ~ack_q;
    assign avs_readdata_o    = rdata_q;

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req & ~ack_q;
            if (avs_read_i && !ack_q) begin
                unique case (avs_address_i)
                    `REG_CTRL:   rdata_q <= {24'h000000, ctrl_q};
                    `REG_PRESET: rdata_q <= {15'h0000, preset_q};
                    `REG_STATUS: rdata_q <= {26'h0000000, set_busy, fault_q, 1'b0} >> 1;
                    `REG_POS:    rdata_q <= {15'h0000, pos_q};
                    default:     rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // bus write beats a link parameter write in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            ctrl_q   <= `CTRL_RST;
            preset_q <= `PRESET_RST;
        end else if (bus_we && avs_address_i == `REG_CTRL) begin
            ctrl_q <= (ctrl_q & ~bmask[7:0]) | (avs_writedata_i[7:0] & bmask[7:0]);
        end else if (bus_we && avs_address_i == `REG_PRESET) begin
            preset_q <= (preset_q & ~bmask[16:0]) | (avs_writedata_i[16:0] & bmask[16:0]);
        end else if (par_we && biss) begin
            unique case (par_addr)
                `PAR_RES:   ctrl_q[`CTRL_RES_LO +: 3] <= par_data[2:0];
                `PAR_GRAY:  ctrl_q[`CTRL_GRAY]     <= par_data[0];
                `PAR_DIR:   ctrl_q[`CTRL_DIR_INV]  <= par_data[0];
                `PAR_ALARM: ctrl_q[`CTRL_ALARM_EN] <= par_data[0];
                `PAR_WARN:  ctrl_q[`CTRL_WARN_EN]  <= par_data[0];
                default:    ctrl_q <= ctrl_q;
            endcase
        end
    end

    // direction reference taken once the synchroniser has filled
    logic [1:0] init_q;
    logic       dir_ref_q;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            init_q    <= 2'h0;
            dir_ref_q <= 1'b0;
        end else if (init_q != 2'h3) begin
            init_q    <= init_q + 2'h1;
            dir_ref_q <= dir_s_q[1];
        end
    end

    // sticky faults; set wins over clear, clear only allowed in biss mode
    logic [3:0] fault_set;
    assign fault_set = {(init_q == 2'h3) && (dir_s_q[1] != dir_ref_q),
                        temp_err_i, emitter_err_i, sensor_err_i};
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            fault_q <= 4'h0;
        end else if (bus_we && avs_address_i == `REG_STATUS && biss) begin
            fault_q <= (fault_q & ~avs_writedata_i[3:0]) | fault_set;
        end else begin
            fault_q <= fault_q | fault_set;
        end
    end
    assign led_o      = (|fault_q) | set_busy;
    assign status_n_o = ~led_o;

    // zero-set filter and processing time
    logic [31:0] filt_cnt_q, proc_cnt_q;
    logic        set_fire;
    logic [16:0] dir_pos, offset_q;
    logic        dir_ccw;
    assign dir_ccw  = dir_s_q[1] ^ ctrl_q[`CTRL_DIR_INV];
    assign dir_pos  = dir_ccw ? 17'(-raw_pos_i) : raw_pos_i;
    assign set_fire = filt_cnt_q == (SET_FILT_CYC - 1);
    assign set_busy = proc_cnt_q != 32'h0;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            filt_cnt_q <= 32'h0;
            proc_cnt_q <= 32'h0;
            offset_q   <= 17'h00000;
        end else begin
            if (!(set_s_q[1] | key_s_q[1]))
                filt_cnt_q <= 32'h0;
            else if (filt_cnt_q < SET_FILT_CYC)
                filt_cnt_q <= filt_cnt_q + 32'h1;
            if (set_fire) begin
                offset_q   <= dir_pos;
                proc_cnt_q <= SET_PROC_CYC;
            end else if (set_busy) begin
                proc_cnt_q <= proc_cnt_q - 32'h1;
            end
        end
    end

    // position refresh well above 100 kHz, frozen while set is processing
    logic [7:0] ref_cnt_q;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            ref_cnt_q <= 8'h00;
            pos_q     <= 17'h00000;
        end else if (ref_cnt_q == 8'(REF_CYC - 1)) begin
            ref_cnt_q <= 8'h00;
            if (!set_busy)
                pos_q <= dir_pos - offset_q + preset_q;
        end else begin
            ref_cnt_q <= ref_cnt_q + 8'h01;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            inc_a_o <= 1'b0;
            inc_b_o <= 1'b0;
        end else begin
            inc_a_o <= pos_q[`INC_A_BIT];
            inc_b_o <= pos_q[`INC_A_BIT] ^ pos_q[`INC_B_BIT];
        end
    end

    // frame builder
    logic [16:0] scaled;
    logic [18:0] payload;
    logic [5:0]  crc;
    logic        cds, n_err, n_warn;
    logic [31:0] word;
    logic [5:0]  len;
    logic [7:0]  temp_q;
    logic [2:0]  temp_idx_q;
    logic        cdm_reply_q;
    assign scaled  = pos_q >> (5'(`POS_W) - res);
    assign n_err   = ~((|fault_q) & ctrl_q[`CTRL_ALARM_EN]);
    assign n_warn  = ~(temp_warn_i & ctrl_q[`CTRL_WARN_EN]);
    assign payload = {scaled, n_err, n_warn};
    assign crc     = ~crc6(payload, res + 5'h02);
    assign cds     = cdm_reply_q | temp_q[temp_idx_q];
    always_comb begin
        if (biss) begin
            len  = 6'(res) + 6'h0b;
            word = ((((32'h1 << 1) | 32'(cds)) << (res + 5'h02)) | 32'(payload)) << 6;
            word = word | 32'(crc);
        end else begin
            len  = 6'(res);
            word = ctrl_q[`CTRL_GRAY] ? 32'(scaled ^ (scaled >> 1)) : 32'(scaled);
        end
    end

    // link engine
    link_state_e state_q;
    logic [31:0] tx_q, last_q;
    logic [5:0]  bits_q, last_len_q;
    logic [8:0]  mono_q;
    logic        fresh_q;
    logic [12:0] cdm_q;
    logic        mono_done;
    assign mono_done = mono_q == 9'(MONO_CYC);
    assign par_we    = cdm_q[`CDM_W - 1];
    assign par_addr  = cdm_q[11:8];
    assign par_data  = cdm_q[7:0];
    assign link_data_o = (state_q == LNK_SHIFT) ? tx_q[31] : 1'b0;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_q     <= LNK_IDLE;
            tx_q        <= 32'hffffffff;
            last_q      <= 32'h0;
            bits_q      <= 6'h00;
            last_len_q  <= 6'h00;
            mono_q      <= 9'h000;
            fresh_q     <= 1'b1;
            cdm_q       <= 13'h0000;
            cdm_reply_q <= 1'b0;
            temp_q      <= 8'h00;
            temp_idx_q  <= 3'h7;
        end else begin
            if (par_we)
                cdm_q <= 13'h0000;
            if (ma_fall || ma_rise)
                mono_q <= 9'h000;
            else if (!mono_done)
                mono_q <= mono_q + 9'h001;
            unique case (state_q)
                LNK_IDLE, LNK_MONO: begin
                    if (ma_fall) begin
                        state_q <= LNK_SHIFT;
                        if (fresh_q || biss) begin
                            // latched within three sampling clocks of the request
                            // high lead bit stands until the first rise brings the msb
                            tx_q       <= (word << (6'd31 - len)) | 32'h80000000;
                            last_q     <= (word << (6'd31 - len)) | 32'h80000000;
                            bits_q     <= len;
                            last_len_q <= len;
                            if (biss && !cdm_reply_q) begin
                                temp_idx_q <= temp_idx_q - 3'h1;
                                if (temp_idx_q == 3'h0)
                                    temp_q <= temp_i;
                            end
                        end else begin
                            tx_q   <= last_q;
                            bits_q <= last_len_q;
                        end
                        fresh_q <= 1'b0;
                    end else if (state_q == LNK_MONO && mono_done) begin
                        state_q <= LNK_IDLE;
                        fresh_q <= 1'b1;
                        if (biss)
                            cdm_q <= {cdm_q[11:0], ~ma_s_q[1]};
                    end
                end
                LNK_SHIFT: begin
                    if (ma_rise) begin
                        // each rising edge presents the next bit, msb first
                        tx_q <= {tx_q[30:0], 1'b0};
                        if (bits_q == 6'h00) begin
                            state_q <= LNK_MONO;
                            tx_q    <= 32'h0;
                        end else begin
                            bits_q <= bits_q - 6'h01;
                        end
                    end
                end
                default: state_q <= LNK_IDLE;
            endcase
            cdm_reply_q <= par_we ? 1'b1 : (ma_fall ? 1'b0 : cdm_reply_q);
        end
    end
endmodule
`default_nettype wire
